/* rtl/sdcp_command_port.sv */
// Purpose: APB3 command front end of the SDRAM controller
// Assumes: Register port on ref_clk, APB3 signalling
// Notes: Only the two write-only command registers live here
//
// Function
// - State moves only on state-command writes
// - Hold pready low on a new state-command write while change pending
// - Bits 2-0: 011 pause, 100 configure, 111 active pause
// - Active pause keeps queued transactions
// - Active pause may lead to low power
// - State reported as 2-bit code
// - Direct command register issues single commands
// - Command code from bit 22 and bits 19-18
// - Only programmed gap between direct commands
// - Direct commands accepted only in config/low power
// - Chip field selects external chip
// - Bank field drives bank lines on mode access
// - Bits 13-0 drive address lines on mode access
`timescale 1ns/10ps
module sdcp_command_port (
	input wire logic ref_clk,
	input wire logic reset,
	// APB3 register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timing and arbiter side
	input wire logic [7:0] cmdGap,
	input wire logic queueEmpty,
	output logic [1:0] controllerState,
	output logic drainRequest,
	output logic holdQueue,
	// SDRAM command pins
	output logic memCmdValid,
	output logic [2:0] memCmdCode,
	output logic [3:0] memChipSelN,
	output logic [1:0] memBank,
	output logic [13:0] memAddress
);
	// Carrier between capture and issue
	sdcp_cmd_if cmdLink ();

	// Controller state and pending change
	sdcp_pkg::sdcp_state_t state;
	sdcp_pkg::sdcp_state_t targetState;
	logic changePending;
	logic [7:0] settleCount;
	// Direct command held for the issuer
	logic cmdQueued;
	logic cmdValid;
	sdcp_pkg::sdcp_memcmd_t cmdWord;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Map a state command to its target; valid low for reserved codes
	function automatic logic decode_state_valid(input logic [2:0] code);
		case (code)
			sdcp_pkg::SC_GO: decode_state_valid = 1'b1;
			sdcp_pkg::SC_SLEEP: decode_state_valid = 1'b1;
			sdcp_pkg::SC_WAKEUP: decode_state_valid = 1'b1;
			sdcp_pkg::SC_PAUSE: decode_state_valid = 1'b1;
			sdcp_pkg::SC_CONFIGURE: decode_state_valid = 1'b1;
			sdcp_pkg::SC_ACTIVE_PAUSE: decode_state_valid = 1'b1;
			default: decode_state_valid = 1'b0;
		endcase
	endfunction

	function automatic sdcp_pkg::sdcp_state_t decode_state_target(input logic [2:0] code);
		case (code)
			sdcp_pkg::SC_GO: decode_state_target = sdcp_pkg::SDCP_RDY;
			sdcp_pkg::SC_SLEEP: decode_state_target = sdcp_pkg::SDCP_LP;
			sdcp_pkg::SC_WAKEUP: decode_state_target = sdcp_pkg::SDCP_PAU;
			sdcp_pkg::SC_PAUSE: decode_state_target = sdcp_pkg::SDCP_PAU;
			sdcp_pkg::SC_CONFIGURE: decode_state_target = sdcp_pkg::SDCP_CFG;
			sdcp_pkg::SC_ACTIVE_PAUSE: decode_state_target = sdcp_pkg::SDCP_PAU;
			default: decode_state_target = sdcp_pkg::SDCP_CFG;
		endcase
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic accessPhase;
	logic stateWrite;
	logic directWrite;
	logic [2:0] stateCode;
	logic directAllowed;
	assign accessPhase = psel && penable && pwrite;
	assign stateWrite = accessPhase && (paddr == sdcp_pkg::OFS_STATE_CMD);
	assign directWrite = accessPhase && (paddr == sdcp_pkg::OFS_DIRECT_CMD);
	assign stateCode = pwdata[sdcp_pkg::STATE_CMD_LSB +: 3];
	assign directAllowed = (state == sdcp_pkg::SDCP_CFG) || (state == sdcp_pkg::SDCP_LP);

	// Pready is a flop: raised one cycle into the access phase when it may finish
	logic canFinish;
	always_comb begin
		canFinish = 1'b1;
		if (stateWrite && changePending) begin
			canFinish = 1'b0;
		end else if (directWrite && directAllowed && !cmdQueued) begin
			canFinish = 1'b0;
		end
	end

	// Access ends one cycle after it may finish; never two cycles running
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready && canFinish;
		end
	end

	// No error response; refused writes complete quietly
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Both registers are write-only, so reads return zero
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// Controller state machine
	// ----------------------------------------
	// A change is taken on the first unstalled cycle of an access only
	logic takeState;
	assign takeState = stateWrite && !changePending && !pready && decode_state_valid(stateCode);

	// ----------------------------------------
	// Pending change bookkeeping
	// ----------------------------------------
	// Change completes once settled and, for plain pause, drained
	logic stateDone;
	assign stateDone = changePending && (settleCount == 8'h00) && (!drainRequest || queueEmpty);

	// Pending flag blocks a second change until the first is done
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			changePending <= 1'b0;
		end else if (takeState) begin
			changePending <= 1'b1;
		end else if (stateDone) begin
			changePending <= 1'b0;
		end
	end

	// Target is kept from the accepted command until it completes
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			targetState <= sdcp_pkg::SDCP_CFG;
		end else if (takeState) begin
			targetState <= decode_state_target(stateCode);
		end
	end

	// Settle timer; plain pause still waits for the queue after it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			settleCount <= 8'h00;
		end else if (takeState) begin
			settleCount <= sdcp_pkg::STATE_SETTLE_CYCLES;
		end else if (settleCount != 8'h00) begin
			settleCount <= settleCount - 8'h01;
		end
	end

	// Only completion of a pending command moves the state
	sdcp_pkg::sdcp_state_t next_state;
	always_comb begin
		next_state = state;
		if (stateDone) begin
			case (targetState)
				sdcp_pkg::SDCP_CFG: next_state = sdcp_pkg::SDCP_CFG;
				sdcp_pkg::SDCP_RDY: next_state = sdcp_pkg::SDCP_RDY;
				sdcp_pkg::SDCP_PAU: next_state = sdcp_pkg::SDCP_PAU;
				sdcp_pkg::SDCP_LP: next_state = sdcp_pkg::SDCP_LP;
				default: next_state = state;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= sdcp_pkg::SDCP_CFG;
		end else begin
			state <= next_state;
		end
	end

	// Drain only for plain pause; the request drops once the change is done
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			drainRequest <= 1'b0;
		end else if (takeState) begin
			drainRequest <= (stateCode == sdcp_pkg::SC_PAUSE);
		end else if (!changePending) begin
			drainRequest <= 1'b0;
		end
	end

	// Active pause freezes the queue through low power until ready again
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			holdQueue <= 1'b0;
		end else if (takeState && stateCode == sdcp_pkg::SC_ACTIVE_PAUSE) begin
			holdQueue <= 1'b1;
		end else if (!changePending && state == sdcp_pkg::SDCP_RDY) begin
			holdQueue <= 1'b0;
		end
	end

	// Reported state code
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			controllerState <= sdcp_pkg::ST_CONFIG;
		end else begin
			case (state)
				sdcp_pkg::SDCP_CFG: controllerState <= sdcp_pkg::ST_CONFIG;
				sdcp_pkg::SDCP_RDY: controllerState <= sdcp_pkg::ST_READY;
				sdcp_pkg::SDCP_PAU: controllerState <= sdcp_pkg::ST_PAUSED;
				sdcp_pkg::SDCP_LP: controllerState <= sdcp_pkg::ST_LOW_POWER;
				default: controllerState <= sdcp_pkg::ST_CONFIG;
			endcase
		end
	end

	// ----------------------------------------
	// Direct command capture
	// ----------------------------------------
	// One-shot flag stops a stalled access from queueing twice
	logic latchCmd;
	logic handOff;
	assign latchCmd = directWrite && directAllowed && !cmdValid && !cmdQueued;
	assign handOff = cmdValid && cmdLink.ready;

	// Command waits here until the issuer takes it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmdValid <= 1'b0;
		end else if (handOff) begin
			cmdValid <= 1'b0;
		end else if (latchCmd) begin
			cmdValid <= 1'b1;
		end
	end

	// Queued flag lets the access finish; setting wins over the clear
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmdQueued <= 1'b0;
		end else if (handOff) begin
			cmdQueued <= 1'b1;
		end else if (pready) begin
			cmdQueued <= 1'b0;
		end
	end

	// Fields captured once per accepted write
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmdWord <= '0;
		end else if (latchCmd) begin
			cmdWord.code <= {pwdata[sdcp_pkg::EXT_CMD_BIT], pwdata[sdcp_pkg::MEM_CMD_LSB +: 2]};
			cmdWord.chip <= pwdata[sdcp_pkg::CHIP_LSB +: 2];
			cmdWord.bank <= pwdata[sdcp_pkg::BANK_LSB +: 2];
			cmdWord.modeAddress <= pwdata[sdcp_pkg::MODE_ADDR_LSB +: 14];
		end
	end

	// Hand the held command to the issuer
	assign cmdLink.valid = cmdValid;
	assign cmdLink.cmd = cmdWord;

	// ----------------------------------------
	// Pin side
	// ----------------------------------------
	sdcp_mem_issue issue (
		.ref_clk(ref_clk),
		.reset(reset),
		.cmdGap(cmdGap),
		.cmdIn(cmdLink),
		.memCmdValid(memCmdValid),
		.memCmdCode(memCmdCode),
		.memChipSelN(memChipSelN),
		.memBank(memBank),
		.memAddress(memAddress)
	);
endmodule

/* rtl/sdcp_pkg.sv */
// Purpose: Shared constants and types of the SDRAM command port
// Assumes: APB3 register port, 32-bit data
// Notes: Offsets are byte addresses
package sdcp_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] OFS_STATE_CMD = 12'h004;
	localparam logic [11:0] OFS_DIRECT_CMD = 12'h008;
	localparam logic [31:0] STATE_CMD_RESET = 32'h00000000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int STATE_CMD_LSB = 0;
	localparam int EXT_CMD_BIT = 22;
	localparam int CHIP_LSB = 20;
	localparam int MEM_CMD_LSB = 18;
	localparam int BANK_LSB = 16;
	localparam int MODE_ADDR_LSB = 0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [7:0] STATE_SETTLE_CYCLES = 8'h04;
	localparam logic [7:0] CMD_GAP_RESET = 8'h02;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [2:0] SC_GO = 3'h0;
	localparam logic [2:0] SC_SLEEP = 3'h1;
	localparam logic [2:0] SC_WAKEUP = 3'h2;
	localparam logic [2:0] SC_PAUSE = 3'h3;
	localparam logic [2:0] SC_CONFIGURE = 3'h4;
	localparam logic [2:0] SC_ACTIVE_PAUSE = 3'h7;

	localparam logic [2:0] MC_PRECHARGE_ALL = 3'h0;
	localparam logic [2:0] MC_AUTO_REFRESH = 3'h1;
	localparam logic [2:0] MC_MODE_REG = 3'h2;
	localparam logic [2:0] MC_NOP = 3'h3;
	localparam logic [2:0] MC_DEEP_POWER_DOWN = 3'h4;

	localparam logic [1:0] ST_CONFIG = 2'h0;
	localparam logic [1:0] ST_READY = 2'h1;
	localparam logic [1:0] ST_PAUSED = 2'h2;
	localparam logic [1:0] ST_LOW_POWER = 2'h3;

	typedef enum logic [1:0] {
		SDCP_CFG,
		SDCP_RDY,
		SDCP_PAU,
		SDCP_LP
	} sdcp_state_t;

	typedef struct packed {
		logic [2:0] code;
		logic [1:0] chip;
		logic [1:0] bank;
		logic [13:0] modeAddress;
	} sdcp_memcmd_t;
endpackage

/* rtl/sdcp_cmd_if.sv */
// Purpose: Carrier of one memory command between decode and issue
// Assumes: Single clock domain
// Notes: Valid/ready handshake, one word per beat
`timescale 1ns/10ps
interface sdcp_cmd_if;
	logic valid;
	logic ready;
	sdcp_pkg::sdcp_memcmd_t cmd;

	modport src (output valid, output cmd, input ready);
	modport dst (input valid, input cmd, output ready);
endinterface

/* rtl/sdcp_mem_issue.sv */
// Purpose: Drives one queued command onto the SDRAM command pins
// Assumes: Gap count comes from the timing registers
// Notes: Only the programmed gap separates commands
`timescale 1ns/10ps
module sdcp_mem_issue (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] cmdGap,
	sdcp_cmd_if.dst cmdIn,
	output logic memCmdValid,
	output logic [2:0] memCmdCode,
	output logic [3:0] memChipSelN,
	output logic [1:0] memBank,
	output logic [13:0] memAddress
);
	logic [7:0] gapCount;

	// ----------------------------------------
	// Issue and spacing
	// ----------------------------------------
	assign cmdIn.ready = (gapCount == 8'h00);

	// One pin cycle per command, then wait out the programmed gap
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			gapCount <= 8'h00;
			memCmdValid <= 1'b0;
			memCmdCode <= sdcp_pkg::MC_NOP;
			memChipSelN <= 4'hF;
			memBank <= 2'h0;
			memAddress <= 14'h0000;
		end else if (cmdIn.valid && cmdIn.ready) begin
			gapCount <= cmdGap;
			memCmdValid <= 1'b1;
			memCmdCode <= cmdIn.cmd.code;
			memChipSelN <= ~(4'h1 << cmdIn.cmd.chip);
			if (cmdIn.cmd.code == sdcp_pkg::MC_MODE_REG) begin
				memBank <= cmdIn.cmd.bank;
				memAddress <= cmdIn.cmd.modeAddress;
			end else begin
				memBank <= 2'h0;
				memAddress <= 14'h0000;
			end
		end else begin
			memCmdValid <= 1'b0;
			memChipSelN <= 4'hF;
			if (gapCount != 8'h00) begin
				gapCount <= gapCount - 8'h01;
			end
		end
	end
endmodule

/* testbench/sdcp_cmd_chk.sv */
// Purpose: Port assertions for the SDRAM command port
// Assumes: One clock, async active-high reset
// Notes: Sees only the top module ports
`timescale 1ns/10ps
module sdcp_cmd_chk (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] cmdGap,
	input wire logic [1:0] controllerState,
	input wire logic memCmdValid,
	input wire logic [2:0] memCmdCode,
	input wire logic [3:0] memChipSelN,
	input wire logic [1:0] memBank,
	input wire logic [13:0] memAddress
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic stAcc;
	logic dirAcc;
	logic cfgOrLp;
	logic [7:0] sinceCmd;
	logic [7:0] sinceSt;
	assign stAcc = psel && penable && pwrite && paddr == sdcp_pkg::OFS_STATE_CMD;
	assign dirAcc = psel && penable && pwrite && paddr == sdcp_pkg::OFS_DIRECT_CMD;
	assign cfgOrLp = controllerState == sdcp_pkg::ST_CONFIG || controllerState == sdcp_pkg::ST_LOW_POWER;
	// Cycles since last pin command, saturating so it never wraps
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) sinceCmd <= 8'hFF;
		else if (memCmdValid) sinceCmd <= 8'h00;
		else if (sinceCmd != 8'hFF) sinceCmd <= sinceCmd + 8'h01;
	end
	// Cycles since a live state write completed; reserved codes start nothing
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) sinceSt <= 8'hFF;
		else if (stAcc && pready && pwdata[2:0] != 3'h5 && pwdata[2:0] != 3'h6) sinceSt <= 8'h00;
		else if (sinceSt != 8'hFF) sinceSt <= sinceSt + 8'h01;
	end
	sequence s_dirStart;
		dirAcc && !$past(penable);
	endsequence
	sequence s_dirOk;
		s_dirStart ##0 cfgOrLp;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_state_by_write: assert property (!$stable(controllerState) |-> sinceSt < 8'h10)
		else $error("state moved without a state write");
	a_stall_pending: assert property (stAcc && sinceSt < 8'h04 |=> !pready)
		else $error("state write not stalled while pending");
	a_direct_issue: assert property (s_dirOk |-> ##[1:300] memCmdValid)
		else $error("accepted direct command never issued");
	a_ready_after_cmd: assert property (dirAcc && pready && cfgOrLp |-> sinceCmd < 8'h04)
		else $error("direct write ended before command issued");
	a_direct_refused: assert property (s_dirStart ##0 !cfgOrLp |-> !memCmdValid [*4])
		else $error("direct command issued outside config or low power");
	a_cmd_gap: assert property (memCmdValid |-> sinceCmd >= cmdGap)
		else $error("commands closer than programmed gap");
	a_chip_onehot: assert property (memCmdValid |-> $onehot(~memChipSelN))
		else $error("chip select not one-hot with command");
	a_chip_idle: assert property (!memCmdValid |-> memChipSelN == 4'hF)
		else $error("chip select active without command");
	a_mode_fields: assert property (memCmdValid && memCmdCode != sdcp_pkg::MC_MODE_REG |-> memBank == 2'h0 && memAddress == 14'h0)
		else $error("bank or address driven outside mode access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
endmodule

bind sdcp_command_port sdcp_cmd_chk chk (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .cmdGap, .controllerState, .memCmdValid, .memCmdCode, .memChipSelN,
	.memBank, .memAddress);

/* testbench/sdcp_sdram_model.sv */
// Purpose: Memory-side model taking single commands
// Assumes: Commands sampled on ref_clk
// Notes: Passive device, drives nothing back
`timescale 1ns/10ps
module sdcp_sdram_model (
	input wire logic ref_clk,
	input wire logic memCmdValid,
	input wire logic [2:0] memCmdCode,
	input wire logic [3:0] memChipSelN,
	input wire logic [1:0] memBank,
	input wire logic [13:0] memAddress,
	output logic gotCmd,
	output logic [20:0] gotWord
);
	logic [1:0] chipIdx;
	// Chip number from the active-low select
	always_comb begin
		chipIdx = 2'h0;
		for (int i = 0; i < 4; i++) if (!memChipSelN[i]) chipIdx = 2'(i);
	end
	// Latch each command as the device sees it
	always_ff @(posedge ref_clk) begin
		gotCmd <= memCmdValid;
		if (memCmdValid) gotWord <= {memCmdCode, chipIdx, memBank, memAddress};
	end
endmodule

/* testbench/sdram_ctrl_command_port_tb_top.sv */
// Purpose: Self-checking bench of the command port
// Assumes: APB3 driven on falling edges
// Notes: Expected commands queued, matched by a monitor
`timescale 1ns/10ps
module sdram_ctrl_command_port_tb_top;
	logic ref_clk, reset, psel, penable, pwrite, queueEmpty, pready, pslverr;
	logic drainRequest, holdQueue, memCmdValid, gotCmd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [7:0] cmdGap;
	logic [1:0] controllerState, memBank;
	logic [2:0] memCmdCode;
	logic [3:0] memChipSelN;
	logic [13:0] memAddress;
	logic [20:0] gotWord;
	logic [20:0] expQ[$];
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	localparam logic [2:0] CODES [9] = '{3'h3, 3'h1, 3'h2, 3'h0, 3'h7, 3'h1, 3'h5, 3'h6, 3'h4};
	localparam logic [1:0] STATES [9] = '{2'h2, 2'h3, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0};
	sdcp_command_port uut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cmdGap, .queueEmpty, .controllerState, .drainRequest, .holdQueue, .memCmdValid,
		.memCmdCode, .memChipSelN, .memBank, .memAddress);
	sdcp_sdram_model mem (.ref_clk, .memCmdValid, .memCmdCode, .memChipSelN, .memBank, .memAddress,
		.gotCmd, .gotWord);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One APB3 transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		psel = 1'b1;
		pwrite = wr;
		paddr = a;
		pwdata = d;
		@(negedge ref_clk) penable = 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		if (!wr) check(prdata, 32'h0);
		@(negedge ref_clk) psel = 1'b0;
		penable = 1'b0;
	endtask
	// Direct command with random chip, bank, address and reserved bits
	task automatic direct(input logic [2:0] c, input logic take);
		logic [31:0] d;
		d = $urandom();
		d[22] = c[2];
		d[19:18] = c[1:0];
		if (take) expQ.push_back({c, d[21:20], c == sdcp_pkg::MC_MODE_REG ? {d[17:16], d[13:0]} : 16'h0});
		apb(1'b1, sdcp_pkg::OFS_DIRECT_CMD, d);
	endtask
	task automatic state(input logic [2:0] c, input logic [1:0] s);
		rnd = $urandom();
		apb(1'b1, sdcp_pkg::OFS_STATE_CMD, {rnd[31:3], c});
		repeat (8) @(negedge ref_clk);
		check(32'(controllerState), 32'(s));
	endtask
	// ----------------------------------------
	// Clock, ceiling and monitor
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Cycle ceiling, far above the few hundred the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// Each command at the memory takes the oldest note
	always @(posedge ref_clk) begin
		if (gotCmd === 1'b1) begin
			if (expQ.size() == 0) check(32'(gotWord), 32'hFFFFFFFF);
			else check(32'(gotWord), 32'(expQ.pop_front()));
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		queueEmpty = 1'b1;
		rnd = $urandom(32'h028A63E9);
		cmdGap = {3'h0, rnd[4:0]} | 8'h08; // Long enough to stall back-to-back commands
		repeat (5) @(negedge ref_clk);
		reset = 1'b0;
		check(32'(controllerState), 32'(sdcp_pkg::ST_CONFIG));
		check(32'(memChipSelN), 32'hF);
		for (int i = 0; i < 5; i++) direct(3'(i), 1'b1);
		repeat (4) @(negedge ref_clk); // Host-timed init delay
		apb(1'b1, sdcp_pkg::OFS_STATE_CMD, 32'h0);
		state(sdcp_pkg::SC_GO, sdcp_pkg::ST_READY);
		direct(sdcp_pkg::MC_NOP, 1'b0);
		queueEmpty = 1'b0; // Plain pause must wait for the drain
		apb(1'b1, sdcp_pkg::OFS_STATE_CMD, {29'h0, sdcp_pkg::SC_PAUSE});
		repeat (8) @(negedge ref_clk);
		check(32'(drainRequest), 32'h1);
		check(32'(controllerState), 32'(sdcp_pkg::ST_READY));
		queueEmpty = 1'b1;
		repeat (3) @(negedge ref_clk);
		check(32'(controllerState), 32'(sdcp_pkg::ST_PAUSED));
		for (int i = 0; i < 9; i++) begin
			if (i == 4) queueEmpty = 1'b0;
			state(CODES[i], STATES[i]);
			if (i >= 3 && i <= 5) check(32'(holdQueue), 32'(i != 3));
			if (i == 4) queueEmpty = 1'b1;
			if (i == 1) direct(sdcp_pkg::MC_MODE_REG, 1'b1); // Low power here, so the command is accepted
			if (i == 2) direct(sdcp_pkg::MC_AUTO_REFRESH, 1'b0);
		end
		apb(1'b0, 12'h00C, 32'h0);
		apb(1'b0, sdcp_pkg::OFS_STATE_CMD, 32'h0);
		repeat (10) @(negedge ref_clk);
		check(32'(expQ.size()), 32'h0);
		stop_test();
	end
endmodule
